// >>> inc/twm_bit_if.sv
// Purpose: command path between controller and bit engine
// Assumes: both ends on sys_clk
// Notes: cmd_valid is offered for one cycle only, and the engine takes it only while idle
`timescale 1ns/100ps
interface twm_bit_if;
  import twm_pkg::*;
  logic cmd_valid; // command offered
  twm_cmd_t cmd; // what to put on the wire
  logic [7:0] tx_byte; // byte for a byte command
  logic done; // one-cycle pulse at end of command
  logic ack; // acknowledge seen low
  logic arb_lost; // lost arbitration, bus released
  logic bus_busy; // a start seen on the bus, by any master, no stop yet
  modport ctl(output cmd_valid, cmd, tx_byte, input done, ack, arb_lost, bus_busy);
  modport eng(input cmd_valid, cmd, tx_byte, output done, ack, arb_lost, bus_busy);
endinterface

// >>> inc/twm_pkg.sv
// Purpose: shared constants and types of the two-wire master transmitter
// Assumes: 50 MHz system clock, 32-bit AHB-Lite register access
// Notes: status codes are kept with the prescaler bits at zero
package twm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00; // bus_control_register
  localparam logic [7:0] STAT_OFS = 8'h04; // bus_status_register
  localparam logic [7:0] DATA_OFS = 8'h08; // shift_data_register
  // ----------------------------------------
  // control bit positions
  // ----------------------------------------
  localparam int CB_FLAG = 7; // event flag, write one to clear
  localparam int CB_ACKEN = 6; // ack_enable, stored only here
  localparam int CB_STA = 5; // start_request
  localparam int CB_STO = 4; // stop_request
  localparam int CB_WC = 3; // write_collision_flag
  localparam int CB_EN = 2; // interface enable
  localparam int CB_IE = 0; // event_interrupt_enable
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // ----------------------------------------
  // status codes
  // ----------------------------------------
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK = 8'h28;
  localparam logic [7:0] ST_D_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  // ----------------------------------------
  // timing: bit period and quarter-bit tick
  // ----------------------------------------
  localparam int CLK_NS = 20;
  localparam int BIT_NS = 10000;
  localparam logic [7:0] QTR_CYC = 8'(BIT_NS / (4 * CLK_NS));
  // ----------------------------------------
  // engine commands and controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TWM_NONE = 2'b00,
    TWM_START = 2'b01,
    TWM_STOP = 2'b10,
    TWM_BYTE = 2'b11
  } twm_cmd_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_STOP = 3'b001,
    C_START = 3'b010,
    C_BYTE = 3'b011,
    C_HOLD = 3'b100
  } twm_ctl_t;
endpackage

// >>> logic/twm_bit_engine.sv
// Purpose: wire-level start, stop and byte sequencer with bus monitor
// Assumes: open-drain pins, pins synchronised here by two flops
// Notes: clock stretching honoured while the clock line is released
`timescale 1ns/100ps
module twm_bit_engine (
  input wire logic sys_clk,
  input wire logic rst_n,
  twm_bit_if.eng bif,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  import twm_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] div; // quarter-bit divider
    logic [1:0] q; // quarter within a bit
    twm_cmd_t ph; // running command, none when idle
    logic [3:0] bitn; // bit index, 8 is the ack slot
    logic [7:0] sh; // outgoing shift
    logic scl_oe_n; // low pulls clock low
    logic sda_oe_n; // low pulls data low
    logic scl_s1, scl_s2, sda_s1, sda_s2, sda_p;
    logic busy, done, ack, arb;
  } twm_eng_t;
  twm_eng_t r, next_r;
  logic tick;
  logic adv;
  always_comb begin
    tick = (r.div == 8'h00);
    // wait at the sample point until a stretched clock is released
    adv = tick && !(r.q == 2'd2 && !r.scl_s2);
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.div = tick ? QTR_CYC - 8'h01 : r.div - 8'h01;
    // first flops are read only by the second
    next_r.scl_s1 = scl_i;
    next_r.scl_s2 = r.scl_s1;
    next_r.sda_s1 = sda_i;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_p = r.sda_s2;
    // start or stop by anyone on the bus
    if (r.scl_s2 && r.sda_p && !r.sda_s2) begin
      next_r.busy = 1'b1;
    end else if (r.scl_s2 && !r.sda_p && r.sda_s2) begin
      next_r.busy = 1'b0;
    end
    case (r.ph)
      TWM_NONE: begin
        if (bif.cmd_valid) begin
          next_r.ph = bif.cmd;
          next_r.q = 2'd0;
          next_r.bitn = 4'h0;
          next_r.sh = bif.tx_byte;
          next_r.arb = 1'b0;
        end
      end
      TWM_START: begin
        // also serves as repeated start from a held-low clock
        if (adv) begin
          next_r.q = r.q + 2'd1;
          case (r.q)
            2'd0: next_r.sda_oe_n = 1'b1;
            2'd1: next_r.scl_oe_n = 1'b1;
            2'd2: next_r.sda_oe_n = 1'b0;
            default: begin
              next_r.scl_oe_n = 1'b0;
              next_r.done = 1'b1;
              next_r.ph = TWM_NONE;
            end
          endcase
        end
      end
      TWM_STOP: begin
        if (adv) begin
          next_r.q = r.q + 2'd1;
          case (r.q)
            2'd0: next_r.sda_oe_n = 1'b0;
            2'd1: next_r.scl_oe_n = 1'b1;
            2'd2: next_r.sda_oe_n = 1'b1;
            default: begin
              next_r.done = 1'b1;
              next_r.ph = TWM_NONE;
            end
          endcase
        end
      end
      default: begin
        if (adv) begin
          next_r.q = r.q + 2'd1;
          case (r.q)
            // zero bit drives low, one bit and ack slot are released
            2'd0: next_r.sda_oe_n = (r.bitn == 4'd8) ? 1'b1 : r.sh[7];
            2'd1: next_r.scl_oe_n = 1'b1;
            2'd2: begin
              if (r.bitn == 4'd8) begin
                next_r.ack = !r.sda_s2; // low level is acknowledge
              end else if (r.sh[7] && !r.sda_s2) begin
                // another master won: let go of both lines
                next_r.sda_oe_n = 1'b1;
                next_r.scl_oe_n = 1'b1;
                next_r.arb = 1'b1;
                next_r.done = 1'b1;
                next_r.ph = TWM_NONE;
              end
            end
            default: begin
              next_r.scl_oe_n = 1'b0;
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'd8) begin
                next_r.done = 1'b1;
                next_r.ph = TWM_NONE;
              end
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{div: 8'h00, q: 2'd0, ph: TWM_NONE, bitn: 4'h0, sh: 8'h00,
             scl_oe_n: 1'b1, sda_oe_n: 1'b1, scl_s1: 1'b1, scl_s2: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, busy: 1'b0,
             done: 1'b0, ack: 1'b0, arb: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign bif.done = r.done;
  assign bif.ack = r.ack;
  assign bif.arb_lost = r.arb;
  assign bif.bus_busy = r.busy;
  assign scl_oe_n = r.scl_oe_n;
  assign sda_oe_n = r.sda_oe_n;
endmodule

// >>> logic/twm_master_tx.sv
// Purpose: two-wire master transmitter with AHB-Lite registers
// Assumes: one AHB-Lite slave, zero wait states, 50 MHz sys_clk
// Notes: master receive is only handed off, not carried out
`timescale 1ns/100ps
module twm_master_tx (
  input wire logic sys_clk,
  input wire logic rst_n,
  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // ----------------------------------------
  // two-wire bus, open drain
  // ----------------------------------------
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // ----------------------------------------
  // event request
  // ----------------------------------------
  output logic irq
);
  import twm_pkg::*;

  // ----------------------------------------
  // state of the controller
  // ----------------------------------------
  typedef struct packed {
    twm_ctl_t st; // controller step
    logic [7:0] ctrl; // control bits
    logic [7:0] stat; // status code, low bits zero
    logic [1:0] presc; // stored prescaler bits
    logic [7:0] data; // shift data
    logic own; // we hold the bus
    logic addr_next; // next byte is an address
    logic mr_mode; // handed to receiver
    logic pend_start; // start follows the stop
    logic sent; // command taken by engine
    logic wr_pend; // write data phase next
    logic [7:0] wr_ofs; // address of that write
    logic [31:0] hrdata; // read data register
    logic irq; // registered request
  } twm_top_t;

  twm_top_t r, next_r;
  twm_bit_if bif ();
  logic launch; // software released the held flag
  logic want; // controller needs the engine

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped offsets read as zero, bits above 7 read as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] ofs, input twm_top_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      CTRL_OFS: v[7:0] = s.ctrl;
      // code with prescaler bits added beside it
      STAT_OFS: v[7:0] = {s.stat[7:3], 1'b0, s.presc};
      DATA_OFS: v[7:0] = s.data;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  twm_bit_engine u_eng (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bif(bif.eng),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
  );

  // command offer to the engine
  always_comb begin
    case (r.st)
      C_STOP: want = 1'b1;
      // free bus before a fresh start, not for a repeated one
      C_START: want = r.own || !bif.bus_busy;
      C_BYTE: want = 1'b1;
      default: want = 1'b0;
    endcase
  end
  assign bif.cmd_valid = want && !r.sent;
  assign bif.cmd = (r.st == C_STOP) ? TWM_STOP :
                   (r.st == C_START) ? TWM_START : TWM_BYTE;
  assign bif.tx_byte = r.data;

  // flag release: a one written to the flag while enabled
  always_comb begin
    launch = r.wr_pend && (r.wr_ofs == CTRL_OFS) && hwdata[CB_FLAG]
             && hwdata[CB_EN] && (r.ctrl[CB_FLAG] || r.st == C_IDLE);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    // ---- command bookkeeping ----
    if (bif.cmd_valid) begin
      next_r.sent = 1'b1;
    end
    if (bif.done) begin
      next_r.sent = 1'b0;
    end
    // ---- controller steps ----
    case (r.st)
      C_STOP: begin
        if (bif.done) begin
          next_r.ctrl[CB_STO] = 1'b0; // stop bit clears itself
          next_r.own = 1'b0;
          if (r.pend_start) begin
            next_r.st = C_START; // start after the stop
            next_r.pend_start = 1'b0;
          end else begin
            next_r.st = C_IDLE;
            next_r.stat = ST_IDLE;
          end
        end
      end
      C_START: begin
        if (bif.done) begin
          // repeated start keeps ownership
          next_r.stat = r.own ? ST_RSTART : ST_START;
          next_r.own = 1'b1;
          next_r.addr_next = 1'b1; // an address must follow
          next_r.mr_mode = 1'b0;
          next_r.ctrl[CB_FLAG] = 1'b1;
          next_r.st = C_HOLD;
        end
      end
      C_BYTE: begin
        if (bif.done) begin
          next_r.ctrl[CB_FLAG] = 1'b1;
          next_r.st = C_HOLD;
          next_r.addr_next = 1'b0;
          if (bif.arb_lost) begin
            next_r.stat = ST_ARB;
            next_r.own = 1'b0;
          end else if (r.addr_next && r.data[0]) begin
            // read bit: receiver takes over
            next_r.mr_mode = 1'b1;
            next_r.stat = bif.ack ? ST_AR_ACK : ST_AR_NACK;
          end else if (r.addr_next) begin
            next_r.stat = bif.ack ? ST_AW_ACK : ST_AW_NACK;
          end else begin
            next_r.stat = bif.ack ? ST_D_ACK : ST_D_NACK;
          end
        end
      end
      C_HOLD: begin
        // nothing moves on the wire until software acts
        next_r.st = C_HOLD;
      end
      default: begin
        next_r.st = C_IDLE;
      end
    endcase

    // ---- AHB address phase ----
    next_r.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        next_r.wr_pend = 1'b1;
        next_r.wr_ofs = haddr[7:0];
      end else begin
        next_r.hrdata = rd_mux(haddr[7:0], r);
      end
    end

    // ---- AHB write data phase ----
    if (r.wr_pend) begin
      case (r.wr_ofs)
        CTRL_OFS: begin
          next_r.ctrl[CB_ACKEN] = hwdata[CB_ACKEN];
          next_r.ctrl[CB_STA] = hwdata[CB_STA];
          next_r.ctrl[CB_STO] = hwdata[CB_STO];
          next_r.ctrl[CB_EN] = hwdata[CB_EN];
          next_r.ctrl[CB_IE] = hwdata[CB_IE];
          // a written one clears unless hardware sets it that cycle; a write that disables always clears
          if (hwdata[CB_FLAG] && !(bif.done && r.st != C_STOP)) begin
            next_r.ctrl[CB_FLAG] = 1'b0;
          end
          if (!hwdata[CB_EN]) begin
            // disabled: the interface stops working
            next_r.st = C_IDLE;
            next_r.stat = ST_IDLE;
            next_r.own = 1'b0;
            next_r.ctrl[CB_FLAG] = 1'b0;
            next_r.pend_start = 1'b0;
          end
        end
        STAT_OFS: begin
          next_r.presc = hwdata[1:0];
        end
        DATA_OFS: begin
          if (r.ctrl[CB_FLAG]) begin
            next_r.data = hwdata[7:0];
            next_r.ctrl[CB_WC] = 1'b0;
          end else begin
            next_r.ctrl[CB_WC] = 1'b1; // write dropped
          end
        end
        default: begin
          next_r.wr_ofs = r.wr_ofs; // unmapped: ignored
        end
      endcase
    end

    // ---- action chosen on flag release ----
    if (launch) begin
      next_r.sent = 1'b0;
      if (r.st == C_IDLE || r.stat == ST_ARB) begin
        if (hwdata[CB_STA]) begin
          next_r.st = C_START; // wait for free bus
          next_r.own = 1'b0;
        end else begin
          // bus already let go; return to idle with the idle status
          next_r.st = C_IDLE;
          next_r.stat = ST_IDLE;
          next_r.own = 1'b0;
        end
      end else if (hwdata[CB_STO]) begin
        next_r.st = C_STOP;
        next_r.pend_start = hwdata[CB_STA];
      end else if (hwdata[CB_STA]) begin
        next_r.st = C_START; // repeated start
      end else if (r.mr_mode) begin
        next_r.st = C_HOLD; // receive side not in this block
      end else begin
        next_r.st = C_BYTE; // address or data goes out
      end
    end

    // ---- interrupt request ----
    next_r.irq = next_r.ctrl[CB_FLAG] && next_r.ctrl[CB_IE];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: C_IDLE, ctrl: CTRL_RST, stat: ST_IDLE, presc: PRESC_RST,
             data: 8'hFF, own: 1'b0, addr_next: 1'b0, mr_mode: 1'b0,
             pend_start: 1'b0, sent: 1'b0, wr_pend: 1'b0, wr_ofs: 8'h00,
             hrdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states keep the slave simple; reads cost one flop
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = r.irq;
  // open drain: only ever pulls low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
endmodule

// >>> verif/twm_master_tx_asserts.sv
// Purpose: concurrent checks on the ports of the two-wire master transmitter
// Assumes: one clock domain, bound from the bench
// Notes: bit slots are counted from the design's own clock-line releases
`timescale 1ns/100ps
module twm_master_tx_asserts import twm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic irq
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic ph_wr; // a write address phase was taken
  logic [7:0] ph_a; // its offset
  logic prev_scl; // last clock enable
  logic prev_sda; // last data enable
  logic [3:0] bits; // clock releases since the last start, modulo nine
  wire rise_scl = scl_oe_n & ~prev_scl;
  wire start_now = prev_scl & scl_oe_n & prev_sda & ~sda_oe_n;
  // track bus phases and bit slots
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr <= 1'b0;
      ph_a <= 8'h00;
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      bits <= 4'h0;
    end else begin
      if (hready) begin
        ph_wr <= hsel & htrans[1] & hwrite;
        ph_a <= haddr[7:0];
      end
      prev_scl <= scl_oe_n;
      prev_sda <= sda_oe_n;
      // a start restarts the count, so stray releases never pile up
      if (start_now) begin
        bits <= 4'h0;
      end else if (rise_scl) begin
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_ctl_wr;
    ph_wr && ph_a == CTRL_OFS && hready;
  endsequence
  sequence s_stop;
    $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n);
  endsequence
  property p_fixed;
    hreadyout && !hresp && !scl_o && !sda_o;
  endproperty
  property p_rd_hi;
    hrdata[31:8] == 24'h0;
  endproperty
  property p_irq_clear;
    s_ctl_wr ##0 (hwdata[CB_FLAG] && irq) |-> ##[1:2] !irq;
  endproperty
  property p_irq_mask;
    s_ctl_wr ##0 !hwdata[CB_IE] |-> ##2 !irq;
  endproperty
  property p_suspend;
    irq && $past(irq) |-> $stable(scl_oe_n) && $stable(sda_oe_n);
  endproperty
  property p_start;
    start_now |-> ##1 scl_oe_n[*8] ##[90:190] !scl_oe_n;
  endproperty
  property p_stop;
    s_stop |-> ##1 (sda_oe_n && scl_oe_n)[*8];
  endproperty
  property p_ack_slot;
    rise_scl && bits == 4'h8 |-> sda_oe_n;
  endproperty
  a_fixed: assert property (p_fixed) else $error("bus answer or pin level moved");
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared");
  a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
  a_suspend: assert property (p_suspend) else $error("wire moved while flagged");
  a_start: assert property (p_start) else $error("start shape wrong");
  a_stop: assert property (p_stop) else $error("bus not left free");
  a_ack_slot: assert property (p_ack_slot) else $error("ack slot driven");
endmodule

// >>> verif/twm_master_tx_bench.sv
// Purpose: self-checking bench of the two-wire master transmitter
// Assumes: slave model on the wire, pull-ups on both lines
// Notes: an extra pull-down on the data line stands for a rival master
`timescale 1ns/100ps
module twm_master_tx_bench;
  import twm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, scl_o, sda_o, scl_oe_n, sda_oe_n, irq;
  logic rival_n = 1'b1; // rival master pull on the data line
  logic nack = 1'b0; // slave answer to the next byte
  logic slow = 1'b0; // slave stretches after a byte
  logic scl_pull_n, sda_pull_n;
  logic [7:0] rx_byte;
  int stops, s0;
  int fail_count = 0;
  int compares = 0;
  logic [31:0] rnd = 32'hD645A341;
  logic [31:0] q; // last read data
  logic [7:0] offs [4] = '{CTRL_OFS, STAT_OFS, DATA_OFS, 8'h0C};
  logic [7:0] exps [4] = '{CTRL_RST, ST_IDLE, 8'hFF, 8'h00};
  // open-drain wires: any party pulling wins
  wire scl_w = scl_oe_n & scl_pull_n;
  wire sda_w = sda_oe_n & sda_pull_n & rival_n;
  always #10 sys_clk = ~sys_clk;
  twm_master_tx i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
  twm_slave_model i_slave (.scl(scl_w), .sda(sda_w), .nack(nack), .slow(slow),
    .scl_pull_n(scl_pull_n), .sda_pull_n(sda_pull_n), .rx_byte(rx_byte), .stops(stops));
  // xorshift draw
  function automatic logic [7:0] rb();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd[7:0];
  endfunction
  // control word that clears the flag with the chosen requests
  function automatic logic [7:0] ctl(input logic start_request_col, input logic stop_request_col);
    return 8'(1 << CB_FLAG) | 8'(start_request_col << CB_STA) | 8'(stop_request_col << CB_STO) | 8'(1 << CB_EN)
      | 8'(1 << CB_IE);
  endfunction
  task automatic close_out;
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one edge with hready high, bounded
  task automatic cyc;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask
  // single AHB-Lite word transfer, read data left in q
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    cyc();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    cyc();
    q = hrdata;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 8000) begin
      @(posedge sys_clk);
      n++;
    end
    if (irq !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask
  // optional data load, flag clear, then status and slave byte
  task automatic step(input logic ld, input logic [7:0] d, input logic start_request_col, input logic stop_request_col,
      input logic nk, input logic [7:0] code);
    if (ld) ahb(1'b1, DATA_OFS, d);
    nack <= nk;
    slow <= rnd[9];
    ahb(1'b1, CTRL_OFS, ctl(start_request_col, stop_request_col));
    // the old flag needs a couple of edges to drop
    repeat (4) @(posedge sys_clk);
    if (code == ST_IDLE) repeat (800) @(posedge sys_clk);
    else wait_irq();
    ahb(1'b0, STAT_OFS, 8'h00);
    check("status", code, q[7:0] & 8'hF8);
    if (ld && code != ST_ARB) check("slave byte", d, rx_byte);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    ahb(1'b1, 8'h0C, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, offs[i], 8'h00);
      check("reset value", exps[i], q[7:0]);
    end
    ahb(1'b1, DATA_OFS, 8'h3C);
    ahb(1'b0, CTRL_OFS, 8'h00);
    check("collision", 8'(1 << CB_WC), q[7:0]);
    ahb(1'b0, DATA_OFS, 8'h00);
    check("data kept", 8'hFF, q[7:0]);
    ahb(1'b1, STAT_OFS, 8'h03);
    step(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, ST_START);
    ahb(1'b0, STAT_OFS, 8'h00);
    check("prescaler", 8'h03, {6'h0, q[1:0]});
    // rival wins the first address bit; release, or wait and restart
    for (int k = 0; k < 2; k++) begin
      rival_n <= 1'b0;
      step(1'b1, (rb() & 8'hFE) | 8'h80, 1'b0, 1'b0, 1'b0, ST_ARB);
      ahb(1'b1, CTRL_OFS, ctl(k == 1, 1'b0));
      repeat (600) @(posedge sys_clk);
      check("lines free", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
      check("no event", 8'h00, {7'h0, irq});
      if (k == 0) ahb(1'b1, CTRL_OFS, ctl(1'b1, 1'b0));
      rival_n <= 1'b1;
      wait_irq();
      ahb(1'b0, STAT_OFS, 8'h00);
      check("status", ST_START, q[7:0] & 8'hF8);
    end
    step(1'b1, rb() & 8'hFE, 1'b0, 1'b0, 1'b0, ST_AW_ACK);
    ahb(1'b0, CTRL_OFS, 8'h00);
    check("control", ctl(1'b0, 1'b0), q[7:0]);
    step(1'b1, rb(), 1'b0, 1'b0, 1'b0, ST_D_ACK);
    step(1'b1, rb(), 1'b0, 1'b0, 1'b1, ST_D_NACK);
    step(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, ST_RSTART);
    step(1'b1, rb() & 8'hFE, 1'b0, 1'b0, 1'b1, ST_AW_NACK);
    s0 = stops;
    step(1'b0, 8'h00, 1'b1, 1'b1, 1'b0, ST_START);
    check("stop count", 8'(s0 + 1), 8'(stops));
    ahb(1'b0, CTRL_OFS, 8'h00);
    check("control", ctl(1'b1, 1'b0), q[7:0]);
    step(1'b1, rb() | 8'h01, 1'b0, 1'b0, 1'b1, ST_AR_NACK);
    s0 = stops;
    step(1'b0, 8'h00, 1'b0, 1'b1, 1'b0, ST_IDLE);
    check("stop count", 8'(s0 + 1), 8'(stops));
    check("lines free", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
    ahb(1'b0, CTRL_OFS, 8'h00);
    check("control", ctl(1'b0, 1'b0) & 8'h7F, q[7:0]);
    step(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, ST_START);
    step(1'b1, rb() & 8'hFE, 1'b0, 1'b0, 1'b0, ST_AW_ACK);
    step(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, ST_RSTART);
    step(1'b1, rb() | 8'h01, 1'b0, 1'b0, 1'b0, ST_AR_ACK);
    // flag bit written zero leaves the flag; interrupt enable dropped
    ahb(1'b1, CTRL_OFS, 8'(1 << CB_EN));
    ahb(1'b0, CTRL_OFS, 8'h00);
    check("masked", 8'(1 << CB_EN) | 8'h80, q[7:0]);
    check("irq", 8'h00, {7'h0, irq});
    close_out();
  end
endmodule
bind twm_master_tx twm_master_tx_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));

// >>> verif/twm_slave_model.sv
// Purpose: behavioural slave receiver on the two-wire bus
// Assumes: pull-ups, so a released line reads high
// Notes: acks the ninth bit unless told not to; may stretch the clock
`timescale 1ns/100ps
module twm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic slow,
  output logic scl_pull_n,
  output logic sda_pull_n,
  output logic [7:0] rx_byte,
  output int stops
);
  int cnt = 0; // bits seen in this byte
  logic [7:0] sh = 8'h00; // incoming byte, msb first
  initial begin
    scl_pull_n = 1'b1;
    sda_pull_n = 1'b1;
    rx_byte = 8'h00;
    stops = 0;
  end
  // start or stop while the clock is high frames the byte count
  always @(sda) begin
    if (scl === 1'b1) begin
      cnt = 0;
      sda_pull_n = 1'b1;
      if (sda === 1'b1) stops++;
    end
  end
  // data is sampled on the clock rising edge
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 8) rx_byte = sh;
    if (cnt < 9) cnt++;
  end
  // ack pulled low after the eighth bit, released after the ninth
  always @(negedge scl) begin
    if (cnt == 8) sda_pull_n = nack;
    if (cnt == 9) begin
      sda_pull_n = 1'b1;
      cnt = 0;
      // a slow slave holds the clock low before the next byte
      if (slow) begin
        scl_pull_n = 1'b0;
        #3000 scl_pull_n = 1'b1;
      end
    end
  end
endmodule
